// >>> core/sclt_top.sv
`include "sclt_params.svh"

// Function
// - Timer counts event-link pulses in timer mode
// - Reload five, underflow every fifth pulse, continue
// - Run bit one counts, zero stops
// - Mask zero passes request, one blocks it
// - Calendar run bit starts and stops counters
// - Hold request freezes counters, allows access
// - Hold status reads one while held
// - Clearing hold request resumes counting
// - Underflow interrupt wakes processor in stop
// - Underflow flag sticky until software writes zero
// - Gate zero: clock stopped, writes ignored, reset
// - Gate one: calendar registers readable and writable
// - Same gate also controls interval timer
// - Event link routes calendar pulse to timer
// - Fixed-cycle select offers once per second
module sclt_top #(
  parameter int unsigned TICK_CYCLES = `SCLT_TICK_CYCLES,
  parameter int unsigned RELOAD_W = 16
) (
  input logic ref_clk,
  input logic reset,
  input logic hsel,
  input logic [31:0] haddr,
  input sclt_pkg::sclt_htrans_t htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input logic stop_state,
  output logic irq_req,
  output logic cpu_wake,
  output logic toggle_output_pin
);
  import sclt_pkg::*;

  localparam int unsigned PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [PW-1:0] HALF_LAST = PW'(TICK_CYCLES / 2 - 1);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  sclt_bus_e bus_q;
  logic [7:0] a_q;
  logic a_hi_q;
  logic wr_pend_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic take;

  assign take = hsel && htrans[1] && hready;
  assign hreadyout = (bus_q != SCLT_BUS_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      a_q <= 8'h00;
      a_hi_q <= 1'b0;
    end else if (take) begin
      a_q <= haddr[7:0];
      a_hi_q <= (haddr[31:8] == 24'h000000);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite;
    end
  end

  // Reads take one wait state so a write just ahead is visible
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_q <= SCLT_BUS_IDLE;
      hrdata_q <= 32'h00000000;
    end else begin
      case (bus_q)
        SCLT_BUS_IDLE: begin
          if (take && !hwrite) begin
            bus_q <= SCLT_BUS_RDWAIT;
          end
        end
        SCLT_BUS_RDWAIT: begin
          hrdata_q <= rd_mux;
          bus_q <= SCLT_BUS_IDLE;
        end
        default: begin
          bus_q <= SCLT_BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic gate_q;
  logic cal_run_q;
  logic [2:0] cyc_sel_q;
  logic hold_req_q;
  logic hold_st_q;
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [7:0] day_q;
  logic tmr_run_q;
  logic undf_q;
  logic [1:0] tmr_mode_q;
  logic [2:0] tmr_src_q;
  logic [RELOAD_W-1:0] reload_q;
  logic [RELOAD_W-1:0] cnt_q;
  logic evt_sel_q;
  logic irqf_q;
  logic mask_q;
  logic pin_q;
  logic wr_ok;
  logic wr_gated;

  assign wr_ok = wr_pend_q && a_hi_q;
  assign wr_gated = wr_ok && gate_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gate_q <= 1'b0;
    end else if (wr_ok && a_q == `SCLT_A_CLKGATE) begin
      gate_q <= hwdata[`SCLT_B_CLKGATE];
    end
  end

  // Gate low holds calendar and timer state in reset
  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      cal_run_q <= 1'b0;
      cyc_sel_q <= SCLT_CYC_NONE;
    end else if (wr_gated && a_q == `SCLT_A_CAL_CTL0) begin
      cal_run_q <= hwdata[`SCLT_B_CAL_RUN];
      cyc_sel_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      hold_req_q <= 1'b0;
    end else if (wr_gated && a_q == `SCLT_A_CAL_CTL1) begin
      hold_req_q <= hwdata[`SCLT_B_HOLD_REQ];
    end
  end

  // Status follows the request one cycle late
  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      hold_st_q <= 1'b0;
    end else begin
      hold_st_q <= hold_req_q;
    end
  end

  // ----------------------------------------------------------------
  // Calendar
  // ----------------------------------------------------------------
  logic [PW-1:0] pre_q;
  logic cal_live;
  logic sec_tick;
  logic half_tick;
  logic pend_q;
  logic step;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic day_wrap;
  logic cyc_hit;
  logic cyc_tgl_q;
  logic cyc_pulse;

  assign cal_live = gate_q && cal_run_q;
  assign sec_tick = cal_live && (pre_q == TICK_LAST);
  assign half_tick = cal_live && (pre_q == HALF_LAST || pre_q == TICK_LAST);

  always_ff @(posedge ref_clk) begin
    if (reset || !cal_live) begin
      pre_q <= '0;
    end else if (pre_q == TICK_LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // A second that elapses during a hold is applied on release
  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      pend_q <= 1'b0;
    end else if (hold_st_q && sec_tick) begin
      pend_q <= 1'b1;
    end else if (!hold_st_q) begin
      pend_q <= 1'b0;
    end
  end

  assign step = !hold_st_q && (sec_tick || pend_q);
  assign sec_wrap = (sec_q == `SCLT_SEC_MAX);
  assign min_wrap = (min_q == `SCLT_MIN_MAX);
  assign hour_wrap = (hour_q == `SCLT_HOUR_MAX);
  assign day_wrap = (day_q == `SCLT_DAY_MAX);

  // Counters are writable only while held
  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      sec_q <= 8'h00;
    end else if (wr_gated && hold_st_q && a_q == `SCLT_A_SEC) begin
      sec_q <= hwdata[7:0];
    end else if (step) begin
      sec_q <= sec_wrap ? 8'h00 : sec_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      min_q <= 8'h00;
    end else if (wr_gated && hold_st_q && a_q == `SCLT_A_MIN) begin
      min_q <= hwdata[7:0];
    end else if (step && sec_wrap) begin
      min_q <= min_wrap ? 8'h00 : min_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      hour_q <= 8'h00;
    end else if (wr_gated && hold_st_q && a_q == `SCLT_A_HOUR) begin
      hour_q <= hwdata[7:0];
    end else if (step && sec_wrap && min_wrap) begin
      hour_q <= hour_wrap ? 8'h00 : hour_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      day_q <= `SCLT_DAY_FIRST;
    end else if (wr_gated && hold_st_q && a_q == `SCLT_A_DAY) begin
      day_q <= hwdata[7:0];
    end else if (step && sec_wrap && min_wrap && hour_wrap) begin
      day_q <= day_wrap ? `SCLT_DAY_FIRST : day_q + 8'h01;
    end
  end

  // Fixed-cycle pulse source
  always_comb begin
    case (sclt_cyc_e'(cyc_sel_q))
      SCLT_CYC_NONE: cyc_hit = 1'b0;
      SCLT_CYC_HALF: cyc_hit = half_tick;
      SCLT_CYC_SEC: cyc_hit = step;
      SCLT_CYC_MIN: cyc_hit = step && sec_wrap;
      SCLT_CYC_HOUR: cyc_hit = step && sec_wrap && min_wrap;
      SCLT_CYC_DAY: cyc_hit = step && sec_wrap && min_wrap && hour_wrap;
      default: cyc_hit = step && sec_wrap && min_wrap && hour_wrap && day_wrap;
    endcase
  end

  // Toggle is cleared only by reset, so gating off cannot fake an event
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cyc_tgl_q <= 1'b0;
    end else if (cyc_hit) begin
      cyc_tgl_q <= !cyc_tgl_q;
    end
  end

  sclt_evt_sync #(
    .STAGES(2)
  ) sclt_evt_sync_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .tgl_in(cyc_tgl_q),
    .pulse_out(cyc_pulse)
  );

  // ----------------------------------------------------------------
  // Event link and interval timer
  // ----------------------------------------------------------------
  logic tmr_evt;
  logic count_en;
  logic undf;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      evt_sel_q <= 1'b0;
    end else if (wr_ok && a_q == `SCLT_A_EVT_LINK) begin
      evt_sel_q <= hwdata[`SCLT_B_EVT_SEL];
    end
  end

  assign tmr_evt = evt_sel_q && cyc_pulse;
  assign count_en = gate_q && tmr_run_q && tmr_evt &&
    tmr_mode_q == SCLT_MODE_TIMER && tmr_src_q == SCLT_SRC_EVENT;
  assign undf = count_en && (cnt_q <= RELOAD_W'(1));

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      tmr_mode_q <= SCLT_MODE_TIMER;
      tmr_src_q <= 3'h0;
    end else if (wr_gated && a_q == `SCLT_A_TMR_MODE) begin
      tmr_mode_q <= hwdata[1:0];
      tmr_src_q <= hwdata[`SCLT_B_SRC_LO +: 3];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      tmr_run_q <= 1'b0;
    end else if (wr_gated && a_q == `SCLT_A_TMR_CTL) begin
      tmr_run_q <= hwdata[`SCLT_B_TMR_RUN];
    end
  end

  // Set wins over a same-cycle clear; writing one has no effect
  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      undf_q <= 1'b0;
    end else if (undf) begin
      undf_q <= 1'b1;
    end else if (wr_gated && a_q == `SCLT_A_TMR_CTL && !hwdata[`SCLT_B_UNDF]) begin
      undf_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      reload_q <= RELOAD_W'(`SCLT_RST_RELOAD);
    end else if (wr_gated && a_q == `SCLT_A_TMR_RELOAD) begin
      reload_q <= hwdata[RELOAD_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !gate_q) begin
      cnt_q <= RELOAD_W'(`SCLT_RST_RELOAD);
    end else if (wr_gated && a_q == `SCLT_A_TMR_RELOAD) begin
      cnt_q <= hwdata[RELOAD_W-1:0];
    end else if (undf) begin
      cnt_q <= reload_q;
    end else if (count_en) begin
      cnt_q <= cnt_q - RELOAD_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request, mask and port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqf_q <= 1'b0;
    end else if (undf) begin
      irqf_q <= 1'b1;
    end else if (wr_ok && a_q == `SCLT_A_IRQ_REQ) begin
      irqf_q <= hwdata[`SCLT_B_IRQ];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_q <= `SCLT_RST_MASK;
    end else if (wr_ok && a_q == `SCLT_A_IRQ_MASK) begin
      mask_q <= hwdata[`SCLT_B_IRQ];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_q <= 1'b0;
    end else if (wr_ok && a_q == `SCLT_A_PORT) begin
      pin_q <= hwdata[`SCLT_B_PIN];
    end
  end

  assign irq_req = irqf_q && !mask_q;
  assign cpu_wake = irq_req && stop_state;
  assign toggle_output_pin = pin_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    if (a_hi_q) begin
      case (a_q)
        `SCLT_A_CLKGATE: rd_mux[`SCLT_B_CLKGATE] = gate_q;
        `SCLT_A_CAL_CTL0: rd_mux[7:0] = {cal_run_q, 4'h0, cyc_sel_q};
        `SCLT_A_CAL_CTL1: rd_mux[1:0] = {hold_st_q, hold_req_q};
        `SCLT_A_SEC: rd_mux[7:0] = sec_q;
        `SCLT_A_MIN: rd_mux[7:0] = min_q;
        `SCLT_A_HOUR: rd_mux[7:0] = hour_q;
        `SCLT_A_DAY: rd_mux[7:0] = day_q;
        `SCLT_A_TMR_CTL: rd_mux[7:0] = {2'h0, undf_q, 4'h0, tmr_run_q};
        `SCLT_A_TMR_MODE: rd_mux[7:0] = {1'b0, tmr_src_q, 2'h0, tmr_mode_q};
        `SCLT_A_TMR_RELOAD: rd_mux[RELOAD_W-1:0] = cnt_q;
        `SCLT_A_EVT_LINK: rd_mux[`SCLT_B_EVT_SEL] = evt_sel_q;
        `SCLT_A_IRQ_REQ: rd_mux[`SCLT_B_IRQ] = irqf_q;
        `SCLT_A_IRQ_MASK: rd_mux[`SCLT_B_IRQ] = mask_q;
        `SCLT_A_PORT: rd_mux[`SCLT_B_PIN] = pin_q;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_UNDF_RELOAD: assert property (
    undf && !(wr_gated && a_q == `SCLT_A_TMR_RELOAD) |=> cnt_q == $past(reload_q))
    else $error("counter not reloaded at underflow");

  AST_COUNT_DOWN: assert property (
    count_en && !undf && !(wr_gated && a_q == `SCLT_A_TMR_RELOAD)
    |=> cnt_q == $past(cnt_q) - RELOAD_W'(1))
    else $error("counter missed an event");

  AST_RUN_STOP: assert property (
    !tmr_run_q && gate_q && !wr_pend_q |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  AST_UNDF_STICKY: assert property (
    undf |=> undf_q && irqf_q ##1 (undf_q || !gate_q || $past(wr_pend_q)))
    else $error("underflow flag not held");

  AST_MASK_GATE: assert property (
    $rose(irqf_q) |-> irq_req == !mask_q)
    else $error("mask does not steer request");

  AST_WAKE: assert property (
    undf && !mask_q && stop_state |=> cpu_wake || !stop_state)
    else $error("no wake on underflow in stop");

  AST_GATE_RESET: assert property (
    !gate_q |=> cnt_q == RELOAD_W'(`SCLT_RST_RELOAD) && sec_q == 8'h00 && !cal_run_q)
    else $error("gated block not in reset");

  AST_HOLD_ST: assert property (
    $rose(hold_req_q) |=> hold_st_q)
    else $error("hold status not raised");

  AST_HOLD_FREEZE: assert property (
    hold_st_q && !wr_pend_q |=> $stable(sec_q))
    else $error("seconds moved during hold");

  AST_HOLD_RELEASE: assert property (
    $fell(hold_req_q) |=> !hold_st_q)
    else $error("hold status stuck after release");

  AST_CAL_STOP: assert property (
    !cal_run_q |=> pre_q == '0)
    else $error("calendar prescaler ran while stopped");

  AST_LINK: assert property (
    count_en |-> evt_sel_q && cyc_pulse)
    else $error("count without routed event");

endmodule

// >>> core/sclt_params.svh
`ifndef SCLT_PARAMS_SVH
`define SCLT_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCLT_A_CLKGATE 8'h00
`define SCLT_A_CAL_CTL0 8'h04
`define SCLT_A_CAL_CTL1 8'h08
`define SCLT_A_SEC 8'h0c
`define SCLT_A_MIN 8'h10
`define SCLT_A_HOUR 8'h14
`define SCLT_A_DAY 8'h18
`define SCLT_A_TMR_CTL 8'h1c
`define SCLT_A_TMR_MODE 8'h20
`define SCLT_A_TMR_RELOAD 8'h24
`define SCLT_A_EVT_LINK 8'h28
`define SCLT_A_IRQ_REQ 8'h2c
`define SCLT_A_IRQ_MASK 8'h30
`define SCLT_A_PORT 8'h34

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCLT_B_CLKGATE 7
`define SCLT_B_CAL_RUN 7
`define SCLT_B_HOLD_REQ 0
`define SCLT_B_HOLD_ST 1
`define SCLT_B_TMR_RUN 0
`define SCLT_B_UNDF 5
`define SCLT_B_IRQ 6
`define SCLT_B_EVT_SEL 0
`define SCLT_B_PIN 0
`define SCLT_B_SRC_LO 4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SCLT_RST_RELOAD 16'h0005
`define SCLT_RST_MASK 1'b1
`define SCLT_SEC_MAX 8'h3b
`define SCLT_MIN_MAX 8'h3b
`define SCLT_HOUR_MAX 8'h17
`define SCLT_DAY_MAX 8'h1f
`define SCLT_DAY_FIRST 8'h01

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCLT_CLK_PERIOD_NS 100
`define SCLT_SEC_NS 1000000000
`define SCLT_TICK_CYCLES ((`SCLT_SEC_NS) / (`SCLT_CLK_PERIOD_NS))

`endif

// >>> core/sclt_pkg.sv
package sclt_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [1:0] sclt_htrans_t;

  typedef enum logic [2:0] {
    SCLT_CYC_NONE = 3'h0,
    SCLT_CYC_HALF = 3'h1,
    SCLT_CYC_SEC = 3'h2,
    SCLT_CYC_MIN = 3'h3,
    SCLT_CYC_HOUR = 3'h4,
    SCLT_CYC_DAY = 3'h5,
    SCLT_CYC_MON = 3'h6
  } sclt_cyc_e;

  typedef enum logic [1:0] {
    SCLT_MODE_TIMER = 2'h0
  } sclt_mode_e;

  typedef enum logic [2:0] {
    SCLT_SRC_EVENT = 3'h2
  } sclt_src_e;

  typedef enum logic [1:0] {
    SCLT_BUS_IDLE = 2'b01,
    SCLT_BUS_RDWAIT = 2'b10
  } sclt_bus_e;

endpackage

// >>> core/sclt_evt_sync.sv
module sclt_evt_sync #(
  parameter int unsigned STAGES = 2
) (
  input logic ref_clk,
  input logic reset,
  input logic tgl_in,
  output logic pulse_out
);

  logic [STAGES-1:0] sync_q;
  logic last_q;

  // Toggle crossing: each edge of the toggle yields one pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], tgl_in};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_q <= 1'b0;
    end else begin
      last_q <= sync_q[STAGES-1];
    end
  end

  assign pulse_out = sync_q[STAGES-1] ^ last_q;

  AST_EVT_SINGLE: assert property (@(posedge ref_clk) disable iff (reset)
    pulse_out |=> !pulse_out)
    else $error("event pulse longer than one cycle");

endmodule

// >>> testbench/sclt_cpu_model.sv
// ----------------------------------------------------------------
// Processor power model: sleeps on request, leaves stop on wake
// ----------------------------------------------------------------
module sclt_cpu_model (
  input logic ref_clk,
  input logic reset,
  input logic sleep_req,
  input logic cpu_wake,
  output logic stop_state
);
  timeunit 1ns;
  timeprecision 1ps;

  // Wake wins over a sleep request in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stop_state <= 1'b0;
    end else if (stop_state && cpu_wake) begin
      stop_state <= 1'b0;
    end else if (sleep_req) begin
      stop_state <= 1'b1;
    end
  end
endmodule

// >>> testbench/sclt_top_tb.sv
`include "sclt_params.svh"

module sclt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sclt_pkg::*;

  localparam int TICK = 8;
  localparam int RELOAD = 5;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  sclt_htrans_t htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic stop_state;
  logic irq_req;
  logic cpu_wake;
  logic toggle_output_pin;
  logic sleep_req = 1'b0;
  logic irq_prev = 1'b0;
  int cyc = 0;
  int rise_prev = 0;
  int rise_last = 0;
  int err_count = 0;
  int total_checks = 0;

  always #50 ref_clk = ~ref_clk;

  sclt_top #(.TICK_CYCLES(TICK), .RELOAD_W(16)) sclt_top_inst (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_state(stop_state),
    .irq_req(irq_req), .cpu_wake(cpu_wake), .toggle_output_pin(toggle_output_pin)
  );

  sclt_cpu_model sclt_cpu_model_inst (
    .ref_clk(ref_clk), .reset(reset), .sleep_req(sleep_req), .cpu_wake(cpu_wake),
    .stop_state(stop_state)
  );

  // Sampled mid-cycle so the combinational request has settled
  always @(negedge ref_clk) begin
    cyc <= cyc + 1;
    irq_prev <= irq_req;
    if (irq_req === 1'b1 && irq_prev !== 1'b1) begin
      rise_prev <= rise_last;
      rise_last <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single transfer; no pipelining, so one idle cycle between transfers
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask

  task automatic wait_for(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) @(negedge ref_clk);
    check({31'h0, s}, 32'h1);
  endtask

  task poll_hold_clear;
    logic [31:0] x;
    x = 32'h2;
    for (int i = 0; i < 8 && x[1] !== 1'b0; i++) bus(1'b0, `SCLT_A_CAL_CTL1, 32'h0, x);
    check(x, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_gate_map;
    rdc(`SCLT_A_CLKGATE, 32'h0);
    rdc(`SCLT_A_IRQ_MASK, 32'h40);
    wr(`SCLT_A_CAL_CTL0, 32'h82);
    rdc(`SCLT_A_CAL_CTL0, 32'h0);
    rdc(`SCLT_A_TMR_RELOAD, RELOAD);
    wr(`SCLT_A_CLKGATE, 32'h80);
    rdc(`SCLT_A_CLKGATE, 32'h80);
    rdc(`SCLT_A_TMR_RELOAD, RELOAD);
    rdc(32'h3c, 32'h0);
    rdc(32'h100, 32'h0);
    check({31'h0, hresp}, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wr(`SCLT_A_CAL_CTL0, s);
      rdc(`SCLT_A_CAL_CTL0, s);
    end
  endtask

  task t_hold;
    logic [31:0] x;
    wr(`SCLT_A_CAL_CTL0, 32'h02);
    wr(`SCLT_A_CAL_CTL1, 32'h1);
    rdc(`SCLT_A_CAL_CTL1, 32'h3);
    wr(`SCLT_A_SEC, 32'h3a);
    rdc(`SCLT_A_SEC, 32'h3a);
    wr(`SCLT_A_CAL_CTL1, 32'h0);
    poll_hold_clear();
    repeat (4 * TICK) @(posedge ref_clk);
    rdc(`SCLT_A_SEC, 32'h3a);
    wr(`SCLT_A_CAL_CTL1, 32'h1);
    wr(`SCLT_A_CAL_CTL0, 32'h82);
    repeat (4 * TICK) @(posedge ref_clk);
    rdc(`SCLT_A_SEC, 32'h3a);
    wr(`SCLT_A_CAL_CTL1, 32'h0);
    poll_hold_clear();
    repeat (3 * TICK) @(posedge ref_clk);
    bus(1'b0, `SCLT_A_SEC, 32'h0, x);
    check({31'h0, x !== 32'h3a}, 32'h1);
  endtask

  task t_timer;
    logic [31:0] x;
    wr(`SCLT_A_TMR_MODE, 32'h20);
    wr(`SCLT_A_TMR_RELOAD, RELOAD);
    wr(`SCLT_A_EVT_LINK, 32'h0);
    wr(`SCLT_A_IRQ_REQ, 32'h0);
    wr(`SCLT_A_IRQ_MASK, 32'h0);
    wr(`SCLT_A_TMR_CTL, 32'h1);
    repeat (3 * TICK) @(posedge ref_clk);
    rdc(`SCLT_A_TMR_RELOAD, RELOAD);
    wr(`SCLT_A_EVT_LINK, 32'h1);
    wait_for(irq_req, (RELOAD + 1) * TICK + 20);
    rdc(`SCLT_A_TMR_RELOAD, RELOAD);
    rdc(`SCLT_A_TMR_CTL, 32'h21);
    rdc(`SCLT_A_IRQ_REQ, 32'h40);
    wr(`SCLT_A_TMR_CTL, 32'h21);
    rdc(`SCLT_A_TMR_CTL, 32'h21);
    wr(`SCLT_A_TMR_CTL, 32'h01);
    wr(`SCLT_A_IRQ_REQ, 32'h0);
    rdc(`SCLT_A_TMR_CTL, 32'h01);
    wait_for(irq_req, (RELOAD + 1) * TICK + 20);
    // Let the edge monitor record the rise first
    @(posedge ref_clk);
    check(rise_last - rise_prev, RELOAD * TICK);
    wr(`SCLT_A_TMR_CTL, 32'h0);
    wr(`SCLT_A_IRQ_REQ, 32'h0);
    bus(1'b0, `SCLT_A_TMR_RELOAD, 32'h0, x);
    repeat (3 * TICK) @(posedge ref_clk);
    rdc(`SCLT_A_TMR_RELOAD, x);
  endtask

  task t_mask_wake;
    wr(`SCLT_A_IRQ_MASK, 32'h40);
    wr(`SCLT_A_TMR_CTL, 32'h1);
    repeat ((RELOAD + 1) * TICK) @(posedge ref_clk);
    rdc(`SCLT_A_IRQ_REQ, 32'h40);
    check({31'h0, irq_req}, 32'h0);
    wr(`SCLT_A_IRQ_MASK, 32'h0);
    wait_for(irq_req, 2);
    wr(`SCLT_A_IRQ_REQ, 32'h0);
    wr(`SCLT_A_TMR_CTL, 32'h1);
    @(posedge ref_clk);
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    @(negedge ref_clk);
    check({31'h0, stop_state}, 32'h1);
    wait_for(cpu_wake, (RELOAD + 1) * TICK + 20);
    repeat (2) @(negedge ref_clk);
    check({31'h0, stop_state}, 32'h0);
    wr(`SCLT_A_PORT, 32'h1);
    @(negedge ref_clk);
    check({31'h0, toggle_output_pin}, 32'h1);
    wr(`SCLT_A_TMR_CTL, 32'h1);
  endtask

  task t_gate_off;
    wr(`SCLT_A_CLKGATE, 32'h0);
    rdc(`SCLT_A_TMR_CTL, 32'h0);
    rdc(`SCLT_A_SEC, 32'h0);
    wr(`SCLT_A_TMR_CTL, 32'h1);
    wr(`SCLT_A_CLKGATE, 32'h80);
    rdc(`SCLT_A_TMR_CTL, 32'h0);
    rdc(`SCLT_A_TMR_RELOAD, RELOAD);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_gate_map();
    t_hold();
    t_timer();
    t_mask_wake();
    t_gate_off();
    complete_run();
  end

  // Whole run is well under a thousand cycles; generous margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
endmodule
